// File: common/cpc_pkg.sv
// Purpose: shared constants for the codec power and clock register bank
// Assumes: 32-bit ahb-lite data, one register per aligned word
// Notes: printed offsets are word indices; byte address is four times the index
package cpc_pkg;
    localparam logic [31:0] CPC_OFF_ID = 32'h0000_0000;
    localparam logic [31:0] CPC_OFF_PWR = 32'h0000_0008;
    localparam logic [31:0] CPC_OFF_CLK = 32'h0000_0010;
    // extra registers, indices times four
    localparam logic [31:0] CPC_OFF_BASS = 32'h0000_0040;
    localparam logic [31:0] CPC_OFF_AVC = 32'h0000_0050;
    // index form of printed offsets, byte address is four times index
    localparam int CPC_IDX_ID = 0;
    localparam int CPC_IDX_PWR = 2;
    localparam int CPC_IDX_CLK = 4;
    localparam int CPC_IDX_BASS = 16;
    localparam int CPC_IDX_AVC = 20;
    localparam logic [15:0] CPC_PWR_MASK = 16'h0073;
    localparam logic [15:0] CPC_CLK_MASK = 16'h003f;
    localparam logic [15:0] CPC_PWR_RESET = 16'h0000;
    localparam logic [15:0] CPC_CLK_RESET = 16'h0008;
    localparam logic [2:0] CPC_DIV_RESET = 3'h1;
    localparam logic CPC_PLL_RESET = 1'b0;
    localparam int CPC_PWR_ADC_BIT = 6;
    localparam int CPC_PWR_DAC_BIT = 5;
    localparam int CPC_PWR_DAP_BIT = 4;
    localparam int CPC_PWR_OUT_BIT = 1;
    localparam int CPC_PWR_IN_BIT = 0;
    localparam int CPC_CLK_DIV_LSB = 4;
    localparam int CPC_CLK_FS_LSB = 2;
    localparam int CPC_CLK_MCLK_LSB = 0;
    localparam logic [1:0] CPC_MCLK_PLL = 2'h3;
    localparam logic [1:0] CPC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] CPC_HTRANS_SEQ = 2'h3;
    // sample rate codes
    typedef enum logic [1:0] {
        CPC_FS_32K = 2'h0,
        CPC_FS_44K1 = 2'h1,
        CPC_FS_48K = 2'h2,
        CPC_FS_96K = 2'h3
    } cpc_fs_t;
endpackage : cpc_pkg

// File: src/cpc_regs.sv
// Purpose: codec power enables and clock rate registers on ahb-lite
// Assumes: zero wait states, every response okay
// Notes: unmapped addresses read zero, writes there are dropped
// Operation
// R1: id register upper byte is a read-only part identifier, writes ignored
// R2: id register lower byte is a read-only silicon revision
// R3: power bit 6 enables the adc block
// R4: power bit 5 enables the dac block
// R5: power bit 4 enables the audio processor
// R6: power bit 1 enables serial audio output path
// R7: power bit 0 enables serial audio input path
// R8: rate divide bits 5:4 give system rate divided by 1, 2, 4, 6
// R9: master clock ratio is relative to system rate, not divided rate
// R10: system rate bits 3:2 pick 32, 44.1, 48 or 96 khz, reset 48
// R11: master clock bits 1:0 pick 256, 384, 512 times fs, or pll
// R12: host picks pll when master clock is not a standard ratio
// R13: host powers pll and vco amplifier before choosing pll
// R14: host programs pll dividers before choosing pll
// R15: host ramps bass level to lowest around bass enable toggle
// R16: bass control bit 0 turns bass enhancement on or off
// R17: volume control bit 0 turns automatic volume control on or off
// R18: host writes surround select 3 then ramps width back down
// R19: host ramps surround width to 7 before changing surround enable
// R20: reserved bits read zero and ignore writes
`timescale 1ns/1ps
module cpc_regs #(
    parameter logic [7:0] PART_ID = 8'h5c, // arbitrary value
    parameter logic [7:0] REVISION = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // block enables
    output logic adc_block_enable,
    output logic dac_block_enable,
    output logic audio_processor_enable,
    output logic serial_audio_out_enable,
    output logic serial_audio_in_enable,
    // clock configuration
    output logic [1:0] rate_divide,
    output logic [1:0] system_sample_rate,
    output logic [1:0] master_clock_ratio,
    output logic pll_select,
    output logic [2:0] rate_divisor,
    // effects
    output logic bass_enable,
    output logic avc_enable
);
    import cpc_pkg::*;

    // register select, one hot so that a stray code selects nothing
    typedef enum logic [5:0] {
        CPC_SEL_NONE = 6'h01,
        CPC_SEL_ID = 6'h02,
        CPC_SEL_PWR = 6'h04,
        CPC_SEL_CLK = 6'h08,
        CPC_SEL_BASS = 6'h10,
        CPC_SEL_AVC = 6'h20
    } cpc_sel_t;

    // whole address compare; offsets inside a word would alias otherwise
    function automatic cpc_sel_t cpc_decode(input logic [31:0] addr);
        cpc_sel_t sel;
        sel = CPC_SEL_NONE;
        if (addr == CPC_OFF_ID) begin
            sel = CPC_SEL_ID;
        end else if (addr == CPC_OFF_PWR) begin
            sel = CPC_SEL_PWR;
        end else if (addr == CPC_OFF_CLK) begin
            sel = CPC_SEL_CLK;
        end else if (addr == CPC_OFF_BASS) begin
            sel = CPC_SEL_BASS;
        end else if (addr == CPC_OFF_AVC) begin
            sel = CPC_SEL_AVC;
        end
        return sel;
    endfunction : cpc_decode

    // rate divide code to divisor 1, 2, 4 or 6
    function automatic logic [2:0] cpc_div(input logic [1:0] code);
        logic [2:0] d;
        d = 3'h1;
        if (code == 2'h1) begin
            d = 3'h2;
        end else if (code == 2'h2) begin
            d = 3'h4;
        end else if (code == 2'h3) begin
            d = 3'h6;
        end
        return d;
    endfunction : cpc_div

    // reset synchroniser
    logic rst_meta_reg;
    logic rst_meta_next;
    logic rst_sync_reg;
    logic rst_sync_next;
    logic rstn;

    // reset entry is asynchronous, its release waits two edges against metastability
    always_comb begin
        rst_meta_next = 1'b1;
        rst_sync_next = rst_meta_reg;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= rst_meta_next;
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rstn = rst_sync_reg;

    // address phase capture
    logic access;
    cpc_sel_t addr_sel;
    logic wr_pend_reg;
    logic wr_pend_next;
    cpc_sel_t wr_sel_reg;
    cpc_sel_t wr_sel_next;

    // zero wait states: address phase is taken whenever hsel and hready are high and htrans is nonseq or seq
    // hsize is ignored; only whole words are expected
    assign access = hsel && hready && (htrans == CPC_HTRANS_NONSEQ || htrans == CPC_HTRANS_SEQ);
    assign addr_sel = cpc_decode(haddr);

    // write data comes one cycle after its address, so the select is kept
    always_comb begin
        wr_pend_next = access && hwrite;
        wr_sel_next = wr_sel_reg;
        if (access) begin
            wr_sel_next = addr_sel;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg <= CPC_SEL_NONE;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_sel_reg <= wr_sel_next;
        end
    end

    // one write strobe per register, all from the held select
    // the id select has no strobe, so writes there change nothing [R1]
    logic wr_pwr;
    logic wr_clk;
    logic wr_bass;
    logic wr_avc;

    assign wr_pwr = wr_pend_reg && (wr_sel_reg == CPC_SEL_PWR);
    assign wr_clk = wr_pend_reg && (wr_sel_reg == CPC_SEL_CLK);
    assign wr_bass = wr_pend_reg && (wr_sel_reg == CPC_SEL_BASS);
    assign wr_avc = wr_pend_reg && (wr_sel_reg == CPC_SEL_AVC);

    // power enables
    logic [15:0] pwr_reg;
    logic [15:0] pwr_next;

    // reserved bits masked on the way in, so they can never read back set
    always_comb begin
        pwr_next = pwr_reg;
        if (wr_pwr) begin
            pwr_next = hwdata[15:0] & CPC_PWR_MASK; // [R3] [R4] [R5] [R6] [R7] [R20]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_reg <= CPC_PWR_RESET;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // clock configuration
    logic [15:0] clk_reg;
    logic [15:0] clk_next;
    logic [2:0] divisor_reg;
    logic [2:0] divisor_next;
    logic pll_sel_reg;
    logic pll_sel_next;

    // decoded divisor and pll flag kept in flops beside the field they follow
    always_comb begin
        clk_next = clk_reg;
        if (wr_clk) begin
            clk_next = hwdata[15:0] & CPC_CLK_MASK; // [R8] [R10] [R11] [R20]
        end
        divisor_next = cpc_div(clk_next[CPC_CLK_DIV_LSB +: 2]); // [R8]
        // no check of pll power or dividers here; sequencing is up to software
        pll_sel_next = (clk_next[CPC_CLK_MCLK_LSB +: 2] == CPC_MCLK_PLL); // [R11]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_reg <= CPC_CLK_RESET;
            divisor_reg <= CPC_DIV_RESET;
            pll_sel_reg <= CPC_PLL_RESET;
        end else begin
            clk_reg <= clk_next;
            divisor_reg <= divisor_next;
            pll_sel_reg <= pll_sel_next;
        end
    end

    // effect switches; level ramps around them stay with the host
    logic bass_reg;
    logic bass_next;
    logic avc_reg;
    logic avc_next;

    always_comb begin
        bass_next = bass_reg;
        avc_next = avc_reg;
        if (wr_bass) begin
            bass_next = hwdata[0]; // [R16]
        end
        if (wr_avc) begin
            avc_next = hwdata[0]; // [R17]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bass_reg <= 1'b0;
            avc_reg <= 1'b0;
        end else begin
            bass_reg <= bass_next;
            avc_reg <= avc_next;
        end
    end

    // read data
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // next values are returned so a read right behind a write sees the new data
    // unmapped reads fall through to zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (access && !hwrite) begin
            if (addr_sel == CPC_SEL_ID) begin
                rdata_next = {16'h0000, PART_ID, REVISION}; // [R1] [R2]
            end else if (addr_sel == CPC_SEL_PWR) begin
                rdata_next = {16'h0000, pwr_next}; // [R20]
            end else if (addr_sel == CPC_SEL_CLK) begin
                rdata_next = {16'h0000, clk_next}; // [R20]
            end else if (addr_sel == CPC_SEL_BASS) begin
                rdata_next = {31'h0000_0000, bass_next};
            end else if (addr_sel == CPC_SEL_AVC) begin
                rdata_next = {31'h0000_0000, avc_next};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // bus response: never stalls, never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // block enables
    assign adc_block_enable = pwr_reg[CPC_PWR_ADC_BIT]; // [R3]
    assign dac_block_enable = pwr_reg[CPC_PWR_DAC_BIT]; // [R4]
    assign audio_processor_enable = pwr_reg[CPC_PWR_DAP_BIT]; // [R5]
    assign serial_audio_out_enable = pwr_reg[CPC_PWR_OUT_BIT]; // [R6]
    assign serial_audio_in_enable = pwr_reg[CPC_PWR_IN_BIT]; // [R7]

    // clock configuration
    assign rate_divide = clk_reg[CPC_CLK_DIV_LSB +: 2]; // [R8]
    assign rate_divisor = divisor_reg; // [R8]
    assign system_sample_rate = clk_reg[CPC_CLK_FS_LSB +: 2]; // [R10]
    // ratio is passed as is; it scales the undivided system rate [R9]
    assign master_clock_ratio = clk_reg[CPC_CLK_MCLK_LSB +: 2]; // [R11]
    assign pll_select = pll_sel_reg; // [R11]

    // effects
    assign bass_enable = bass_reg; // [R16]
    assign avc_enable = avc_reg; // [R17]
endmodule : cpc_regs

// File: bench/cpc_regs_asserts.sv
// Purpose: port checks for cpc_regs
// Assumes: bench ties hready to hreadyout
// Notes: sees top ports only
`timescale 1ns/1ps
module cpc_regs_asserts #(parameter logic [7:0] PART_ID = 8'h00, parameter logic [7:0] REVISION = 8'h00) (
    // bus
    input wire logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0] htrans, rate_divide, system_sample_rate, master_clock_ratio,
    input wire logic [2:0] hsize, rate_divisor,
    // enables
    input wire logic adc_block_enable, dac_block_enable, audio_processor_enable, serial_audio_out_enable,
    input wire logic serial_audio_in_enable, pll_select, bass_enable, avc_enable
);
    import cpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic take = hsel && hready && htrans[1];
    wire logic wr_pwr = take && hwrite && haddr == CPC_OFF_PWR;
    wire logic wr_clk = take && hwrite && haddr == CPC_OFF_CLK;
    wire logic [4:0] en = {adc_block_enable, dac_block_enable, audio_processor_enable,
        serial_audio_out_enable, serial_audio_in_enable};
    wire logic [5:0] ck = {rate_divide, system_sample_rate, master_clock_ratio};
    a_pll_flag: assert property (pll_select == (master_clock_ratio == CPC_MCLK_PLL))
        else $error("pll flag disagrees with ratio code");
    a_divisor_map: assert property (rate_divisor == (rate_divide == 2'h0 ? 3'h1 : rate_divide == 2'h1 ? 3'h2 :
        rate_divide == 2'h2 ? 3'h4 : 3'h6)) else $error("rate divisor wrong");
    a_pwr_write: assert property (wr_pwr |=> ##1
        en == {$past(hwdata[6:4]), $past(hwdata[1:0])}) else $error("power enables not loaded");
    a_clk_write: assert property (wr_clk |=> ##1 ck == $past(hwdata[5:0]))
        else $error("clock fields not loaded");
    a_id_read: assert property (take && !hwrite && haddr == CPC_OFF_ID |=>
        hrdata == {16'h0, PART_ID, REVISION}) else $error("id read wrong");
    a_pwr_rsvd: assert property (take && !hwrite && haddr == CPC_OFF_PWR |=>
        hrdata[31:7] == 25'h0 && hrdata[3:2] == 2'h0) else $error("reserved power bits not zero");
    a_pwr_hold: assert property ($changed(en) |-> $past(wr_pwr, 2)) else $error("enables moved without write");
    a_clk_hold: assert property ($changed(ck) |-> $past(wr_clk, 2)) else $error("clock fields moved");
endmodule : cpc_regs_asserts
bind cpc_regs cpc_regs_asserts #(.PART_ID(PART_ID), .REVISION(REVISION)) u_chk (.clk, .resetn, .hsel, .hwrite,
    .hready, .hreadyout, .hresp, .haddr, .hwdata, .hrdata, .htrans, .rate_divide, .system_sample_rate,
    .master_clock_ratio, .hsize, .rate_divisor, .adc_block_enable, .dac_block_enable, .audio_processor_enable,
    .serial_audio_out_enable, .serial_audio_in_enable, .pll_select, .bass_enable, .avc_enable);

// File: bench/cpc_regs_tb.sv
// Purpose: self-checking bench for cpc_regs
// Assumes: single ahb-lite master, whole words
// Notes: rows write then read back
`timescale 1ns/1ps
module cpc_regs_tb;
    import cpc_pkg::*;
    typedef struct packed {logic [31:0] a; logic [15:0] d; logic [15:0] r; logic [16:0] o;} cpc_row_t;
    localparam logic [7:0] PID = 8'h3b; // arbitrary value
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, pll_select, bass_enable, avc_enable;
    logic adc_block_enable, dac_block_enable, audio_processor_enable, serial_audio_out_enable, serial_audio_in_enable;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, rate_divide, system_sample_rate, master_clock_ratio;
    logic [2:0] hsize = 0, rate_divisor;
    int mismatches = 0, checked = 0, cycles = 0;
    wire logic [16:0] outs = {adc_block_enable, dac_block_enable, audio_processor_enable, serial_audio_out_enable,
        serial_audio_in_enable, rate_divide, system_sample_rate, master_clock_ratio, pll_select, rate_divisor,
        bass_enable, avc_enable};
    // analog power, pll dividers and level ramps are host steps done outside this bank
    cpc_row_t rows [11] = '{
        '{CPC_OFF_PWR, 16'hffff, 16'h0073, 17'b11111_00_10_00_0_001_00},
        '{CPC_OFF_CLK, 16'hffff, 16'h003f, 17'b11111_11_11_11_1_110_00},
        '{CPC_OFF_CLK, 16'h0016, 16'h0016, 17'b11111_01_01_10_0_010_00},
        '{CPC_OFF_CLK, 16'h0021, 16'h0021, 17'b11111_10_00_01_0_100_00},
        '{CPC_OFF_PWR, 16'h0050, 16'h0050, 17'b10100_10_00_01_0_100_00},
        '{CPC_OFF_ID, 16'hffff, {PID, 8'h01}, 17'b10100_10_00_01_0_100_00},
        '{CPC_OFF_BASS, 16'hffff, 16'h0001, 17'b10100_10_00_01_0_100_10},
        '{CPC_OFF_AVC, 16'h0003, 16'h0001, 17'b10100_10_00_01_0_100_11},
        '{32'hc, 16'hffff, 16'h0000, 17'b10100_10_00_01_0_100_11},
        '{CPC_OFF_PWR, 16'h0022, 16'h0022, 17'b01010_10_00_01_0_100_11},
        '{CPC_OFF_BASS, 16'h0000, 16'h0000, 17'b01010_10_00_01_0_100_01}};
    cpc_regs #(.PART_ID(PID), .REVISION(8'h01)) DUT (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .adc_block_enable, .dac_block_enable,
        .audio_processor_enable, .serial_audio_out_enable, .serial_audio_in_enable, .rate_divide,
        .system_sample_rate, .master_clock_ratio, .pll_select, .rate_divisor, .bass_enable, .avc_enable);
    assign hready = hreadyout;
    initial forever #2 clk = ~clk;
    task end_of_test;
        $display("counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data
    task cmp_outs(input logic [16:0] got, input logic [16:0] exp);
        cmp_data({15'h0, got}, {15'h0, exp});
    endtask : cmp_outs
    // hready is waited on, never assumed
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1;
        haddr <= a;
        htrans <= CPC_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, {16'hffff, rows[i].d});
            bus(rows[i].a, 1'b0, 32'h0);
            cmp_data(rd, {16'h0, rows[i].r});
            cmp_outs(outs, rows[i].o);
            cmp_data({30'h0, hreadyout, hresp}, 32'h2);
            $display("row %0d done", i);
        end
        @(posedge clk) resetn <= 0;
        repeat (2) @(posedge clk);
        cmp_outs(outs, 17'b00000_00_10_00_0_001_00);
        resetn <= 1;
        repeat (3) @(posedge clk);
        bus(CPC_OFF_CLK, 1'b0, 32'h0);
        cmp_data(rd, 32'h8);
        $display("reset test done");
        end_of_test();
    end
endmodule : cpc_regs_tb
